// ===== core/reset_and_interrupt_arbiter.sv
// Reset sequencing, cause recording and interrupt arbitration
`timescale 1ns/1ns
`default_nettype none
module reset_and_interrupt_arbiter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Reset sources
    input wire logic power_up_pulse_i,
    input wire logic watchdog_ovf_i,
    input wire logic supply_trip_i,
    input wire logic debug_entry_reset_i,
    input wire logic vectors_erased_i,
    // Reset pin, open drain
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    // Test voltage sensing and modes
    input wire logic rst_pin_hv_i,
    input wire logic irq_pin_hv_i,
    input wire logic monitor_mode_i,
    input wire logic break_state_i,
    output logic watchdog_disable_o,
    // CPU decode
    input wire logic illegal_op_i,
    input wire logic stop_op_i,
    input wire logic stop_enable_i,
    input wire logic opcode_fetch_i,
    input wire logic unmapped_i,
    input wire logic short_wake_option_i,
    input wire logic insn_done_i,
    input wire logic mask_bit_i,
    input wire logic trap_op_i,
    input wire logic entry_done_i,
    input wire logic [15:0] irq_req_i,
    output logic internal_reset_line_o,
    output logic bus_clk_en_o,
    output logic int_take_o,
    output logic [4:0] vector_o,
    output logic pc_minus1_o,
    output logic stack_index_high_o
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    rst_irq_pkg::seq_t seq_r;
    logic [12:0] cnt_r;
    logic [12:0] wait_r;
    logic [7:0] cause_r;
    logic [15:0] enable_r;
    logic [1:0] ctrl_r;
    logic [4:0] vec_r;
    logic latched_r;
    logic pin_s;
    logic wd_s;
    logic trip_s;
    logic dbg_s;
    logic pin_low_s;
    logic wd_hit;
    logic opc_hit;
    logic fetch_hit;
    logic dbg_hit;
    logic int_rst;
    logic ext_rst;
    logic stop_go;
    logic cnt_done;
    logic any_irq;
    logic [15:0] pend;
    logic [4:0] win_vec;
    logic wb_req;
    logic cause_rd;
    ////////////////////////////////////////////////////////////////////////
    // Reset pin, watchdog, supply trip and debug reset inputs pass two flip-flops
    sync2 u_sync_pin (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .d_i(rst_pin_i), .q_o(pin_s));
    sync2 u_sync_wd (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .d_i(watchdog_ovf_i), .q_o(wd_s));
    sync2 u_sync_trip (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .d_i(supply_trip_i), .q_o(trip_s));
    sync2 u_sync_dbg (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .d_i(debug_entry_reset_i), .q_o(dbg_s));
    ////////////////////////////////////////////////////////////////////////
    // Reset source decode
    // Watchdog gate is purely combinational, no register in the path
    assign watchdog_disable_o = (monitor_mode_i &
        (rst_pin_hv_i | irq_pin_hv_i)) | (break_state_i & rst_pin_hv_i);
    assign wd_hit = wd_s & ~watchdog_disable_o;
    assign opc_hit = illegal_op_i | (stop_op_i & ~stop_enable_i);
    assign fetch_hit = opcode_fetch_i & unmapped_i;
    assign dbg_hit = dbg_s & vectors_erased_i & monitor_mode_i;
    assign int_rst = power_up_pulse_i | wd_hit | opc_hit | fetch_hit
        | dbg_hit | trip_s;
    // External pin low, counted only in the run state
    assign ext_rst = ~pin_s & (seq_r == rst_irq_pkg::ST_RUN);
    assign stop_go = stop_op_i & stop_enable_i & (seq_r == rst_irq_pkg::ST_RUN);
    // Counter starts at zero, so the last cycle of a phase is wait minus one
    assign cnt_done = (cnt_r == wait_r - 13'h0001);
    ////////////////////////////////////////////////////////////////////////
    // Sequencer: pin low phase, internal reset phase, stop and settle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_r <= rst_irq_pkg::ST_PIN_LOW;
            wait_r <= rst_irq_pkg::LONG_SETTLE_CYC + rst_irq_pkg::PIN_LOW_CYC;
        end else if (ce_i) begin
            if (int_rst) begin
                seq_r <= rst_irq_pkg::ST_PIN_LOW;
                wait_r <= (power_up_pulse_i | trip_s)
                    ? rst_irq_pkg::LONG_SETTLE_CYC + rst_irq_pkg::PIN_LOW_CYC
                    : rst_irq_pkg::PIN_LOW_CYC;
            end else begin
                case (seq_r)
                    rst_irq_pkg::ST_RUN: begin
                        if (stop_go) begin
                            seq_r <= rst_irq_pkg::ST_STOP;
                        end
                    end
                    rst_irq_pkg::ST_PIN_LOW: begin
                        if (cnt_done) begin
                            seq_r <= rst_irq_pkg::ST_INTERNAL_RESET_LINE;
                            wait_r <= rst_irq_pkg::INTERNAL_RESET_LINE_EXTRA_CYC;
                        end
                    end
                    rst_irq_pkg::ST_INTERNAL_RESET_LINE: begin
                        if (cnt_done) begin
                            seq_r <= rst_irq_pkg::ST_RUN;
                        end
                    end
                    rst_irq_pkg::ST_STOP: begin
                        // Sample short wake option on exit
                        if (any_irq | trap_op_i | break_state_i | ~pin_s) begin
                            seq_r <= rst_irq_pkg::ST_SETTLE;
                            wait_r <= short_wake_option_i
                                ? rst_irq_pkg::SHORT_SETTLE_CYC
                                : rst_irq_pkg::LONG_SETTLE_CYC;
                        end
                    end
                    rst_irq_pkg::ST_SETTLE: begin
                        if (cnt_done) begin
                            seq_r <= rst_irq_pkg::ST_RUN;
                        end
                    end
                    default: seq_r <= rst_irq_pkg::ST_RUN;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // 13-bit stabilisation counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (ce_i) begin
            if (int_rst) begin
                cnt_r <= '0;
            end else if (stop_go || seq_r == rst_irq_pkg::ST_STOP) begin
                cnt_r <= '0;
            end else if ((seq_r != rst_irq_pkg::ST_RUN) && cnt_done) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 13'h0001;
            end
        end
    end
    // Reset pin open drain and internal reset line
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_o = (seq_r == rst_irq_pkg::ST_PIN_LOW);
    assign internal_reset_line_o = (seq_r == rst_irq_pkg::ST_PIN_LOW)
        | (seq_r == rst_irq_pkg::ST_INTERNAL_RESET_LINE) | ext_rst;
    assign bus_clk_en_o = (seq_r == rst_irq_pkg::ST_RUN);
    ////////////////////////////////////////////////////////////////////////
    // Reset cause register, set wins over read clear
    assign wb_req = cyc_i & stb_i & ~ack_o;
    assign cause_rd = wb_req & ~we_i & (adr_i == rst_irq_pkg::CAUSE_OFS);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_r <= rst_irq_pkg::CAUSE_RST;
        end else if (ce_i) begin
            if (power_up_pulse_i) begin
                cause_r <= rst_irq_pkg::CAUSE_RST;
            end else begin
                cause_r <= (cause_rd ? 8'h00 : cause_r)
                    | ({7'h00, wd_hit} << rst_irq_pkg::WDOG_BIT)
                    | ({7'h00, opc_hit} << rst_irq_pkg::OPC_BIT)
                    | ({7'h00, fetch_hit} << rst_irq_pkg::FETCH_BIT)
                    | ({7'h00, dbg_hit} << rst_irq_pkg::DEBUG_BIT)
                    | ({7'h00, trip_s} << rst_irq_pkg::TRIP_BIT)
                    | ({7'h00, ext_rst} << rst_irq_pkg::PIN_BIT);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Interrupt arbitration
    assign pend = irq_req_i & enable_r;
    assign any_irq = |pend;
    // Lowest index is highest priority; trap beats all sources
    always_comb begin
        win_vec = rst_irq_pkg::VEC_NONE;
        for (int i = rst_irq_pkg::NUM_IRQ - 1; i >= 0; i--) begin
            if (pend[i]) begin
                win_vec = 5'(i + 1);
            end
        end
        if (trap_op_i) begin
            win_vec = rst_irq_pkg::VEC_TRAP;
        end
    end
    // Latch at instruction boundary; hold until serviced (entry_done_i), mask has no effect once latched
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latched_r <= 1'b0;
            vec_r <= rst_irq_pkg::VEC_NONE;
        end else if (ce_i) begin
            if (latched_r) begin
                if (entry_done_i) begin
                    latched_r <= 1'b0;
                end
            end else if (insn_done_i && bus_clk_en_o &&
                (trap_op_i || (!mask_bit_i && any_irq))) begin
                latched_r <= 1'b1;
                vec_r <= win_vec;
            end
        end
    end
    assign int_take_o = latched_r;
    assign vector_o = vec_r;
    assign pc_minus1_o = latched_r & (vec_r != rst_irq_pkg::VEC_TRAP);
    assign stack_index_high_o = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // Wishbone registers, one cycle ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= '0;
            enable_r <= rst_irq_pkg::ENABLE_RST;
            ctrl_r <= rst_irq_pkg::CTRL_RST;
        end else if (ce_i) begin
            ack_o <= wb_req;
            if (wb_req && we_i && adr_i == rst_irq_pkg::ENABLE_OFS) begin
                if (sel_i[0]) enable_r[7:0] <= dat_i[7:0];
                if (sel_i[1]) enable_r[15:8] <= dat_i[15:8];
            end
            if (wb_req && !we_i) begin
                case (adr_i)
                    rst_irq_pkg::CAUSE_OFS: dat_o <= {24'h0, cause_r};
                    rst_irq_pkg::STATUS_OFS: dat_o <= {16'h0, irq_req_i};
                    rst_irq_pkg::ENABLE_OFS: dat_o <= {16'h0, enable_r};
                    rst_irq_pkg::CTRL_OFS: dat_o <= {26'h0, latched_r, vec_r};
                    default: dat_o <= '0;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_pin_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && $rose(seq_r == rst_irq_pkg::ST_INTERNAL_RESET_LINE) |->
        $past(rst_pin_oe_o)) else $error("Pin not driven before reset tail");
    a_wd_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        monitor_mode_i && irq_pin_hv_i |-> watchdog_disable_o)
        else $error("Watchdog not disabled");
    a_opc_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && stop_op_i && !stop_enable_i && !power_up_pulse_i
        |=> cause_r[rst_irq_pkg::OPC_BIT]) else $error("Stop not illegal");
    a_fetch_only: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && unmapped_i && !opcode_fetch_i && !power_up_pulse_i
        && !cause_rd && !$past(cause_r[rst_irq_pkg::FETCH_BIT])
        |=> !cause_r[rst_irq_pkg::FETCH_BIT] || $past(fetch_hit))
        else $error("Data fetch flagged");
    a_internal_reset_line_tail: assert property (@(posedge clk_i) disable iff (rst_i)
        internal_reset_line_o && !rst_pin_oe_o && seq_r == rst_irq_pkg::ST_INTERNAL_RESET_LINE
        |-> cnt_r <= rst_irq_pkg::INTERNAL_RESET_LINE_EXTRA_CYC)
        else $error("Reset tail too long");
    a_stop_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && stop_go && !int_rst |=> cnt_r == 13'h0000)
        else $error("Stop did not clear counter");
    a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && latched_r && !entry_done_i |=> latched_r && $stable(vec_r))
        else $error("Latched interrupt pre-empted");
    a_trap_pc: assert property (@(posedge clk_i) disable iff (rst_i)
        latched_r && vec_r == rst_irq_pkg::VEC_TRAP |-> !pc_minus1_o)
        else $error("Trap stacked PC minus 1");
    a_mask_block: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !latched_r && mask_bit_i && !trap_op_i |=> !latched_r)
        else $error("Masked interrupt taken");
    c_trap: cover property (@(posedge clk_i) latched_r
        && vec_r == rst_irq_pkg::VEC_TRAP);
    c_stop_wake: cover property (@(posedge clk_i)
        seq_r == rst_irq_pkg::ST_SETTLE ##1 seq_r == rst_irq_pkg::ST_RUN);
    c_wd_reset: cover property (@(posedge clk_i) wd_hit ##1 rst_pin_oe_o);
endmodule // reset_and_interrupt_arbiter
`default_nettype wire

// ===== core/rst_irq_pkg.sv
// Constants shared by the reset and interrupt arbiter
// Functional notes
// - Watchdog overflow raises internal reset and sets watchdog_timeout cause flag.
// - Every internal reset source drives the reset pin low.
// - Watchdog disabled combinationally by high test voltage in monitor or break state.
// - Illegal instruction sets bad_opcode_flag and resets the chip.
// - With stop disabled, stop instruction gives a bad opcode reset.
// - Opcode fetch from unmapped address sets bad_fetch_address_flag and resets.
// - Supply trip sets its flag, pin low for 4096 + 32 cycles.
// - After supply trip, CPU released 32 cycles after pin-low interval.
// - Debug entry reset with erased vectors causes internal reset, pin low.
// - Stabilisation counter is 13 bits, times oscillator settling.
// - Stop instruction clears the stabilisation counter.
// - Stop exit waits 32 cycles if short wake set, else 4096.
// - External pin reset leaves counter unchanged; counter free-runs after reset.
// - Interrupt entry stacks registers and sets mask; return restores them.
// - Requests latched and arbitrated at entry, giving a vector constant.
// - Latched interrupt not pre-empted until serviced; clearing the mask does not release it.
// - Hardware interrupt taken at instruction end, mask clear, source enabled.
// - Highest priority pending served first; pending at return served next.
// - Interrupt entry does not stack the index-high register.
// - Software trap interrupts regardless of the mask bit.
// - Software trap stacks PC; hardware interrupt stacks PC minus 1.
// - Priority reset, software trap, then sources 1 to 16 by number.
// - Internal reset other than power-up or supply trip: pin low 32 cycles, internal reset 32 more.
// - Internal reset clears counter; each source sets its own cause flag.
package rst_irq_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned CNT_W = 13;
    localparam logic [12:0] PIN_LOW_CYC = 13'h0020;
    localparam logic [12:0] INTERNAL_RESET_LINE_EXTRA_CYC = 13'h0020;
    localparam logic [12:0] LONG_SETTLE_CYC = 13'h1000;
    localparam logic [12:0] SHORT_SETTLE_CYC = 13'h0020;
    localparam int unsigned NUM_IRQ = 16;
    // Wishbone byte offsets
    localparam logic [3:0] CAUSE_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] ENABLE_OFS = 4'h8;
    localparam logic [3:0] CTRL_OFS = 4'hc;
    // Cause register bit positions
    localparam int unsigned POWER_BIT = 7;
    localparam int unsigned PIN_BIT = 6;
    localparam int unsigned WDOG_BIT = 5;
    localparam int unsigned OPC_BIT = 4;
    localparam int unsigned FETCH_BIT = 3;
    localparam int unsigned DEBUG_BIT = 2;
    localparam int unsigned TRIP_BIT = 1;
    localparam logic [7:0] CAUSE_RST = 8'h80;
    localparam logic [15:0] ENABLE_RST = 16'h0000;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [4:0] VEC_NONE = 5'h00;
    localparam logic [4:0] VEC_TRAP = 5'h11;
    typedef enum {ST_RUN, ST_PIN_LOW, ST_INTERNAL_RESET_LINE, ST_STOP, ST_SETTLE} seq_t;
endpackage : rst_irq_pkg

// ===== core/sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module sync2 (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_r;
    // First stage read only by the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            q_o <= 1'b0;
        end else if (ce_i) begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule // sync2
`default_nettype wire

// ===== verif/cpu_model.sv
// CPU side model: instruction ends, trap decode and stacking delay
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
    input wire logic clk_i,
    input wire logic trap_req_i,
    input wire logic [7:0] entry_dly_i,
    input wire logic int_take_i,
    output logic insn_done_o,
    output logic trap_op_o,
    output logic entry_done_o
);
    logic [2:0] step_r = 3'h0;
    logic [7:0] wait_r = 8'h0;
    initial insn_done_o = 1'h0;
    initial trap_op_o = 1'h0;
    initial entry_done_o = 1'h0;
    // Instruction boundary every eighth cycle, trap decoded there
    always_ff @(posedge clk_i) begin
        step_r <= step_r + 3'h1;
        insn_done_o <= (step_r == 3'h7);
        trap_op_o <= (step_r == 3'h7) && trap_req_i;
    end
    // Stacking and vector fetch end entry_dly plus one cycles after the take
    always_ff @(posedge clk_i) begin
        if (!int_take_i || entry_done_o) begin
            wait_r <= 8'h0;
            entry_done_o <= 1'h0;
        end else begin
            wait_r <= wait_r + 8'h1;
            entry_done_o <= (wait_r == entry_dly_i);
        end
    end
endmodule // cpu_model
`default_nettype wire

// ===== verif/reset_and_interrupt_arbiter_tb.sv
// Bench for the reset and interrupt arbiter
`timescale 1ns/1ns
`default_nettype none
module reset_and_interrupt_arbiter_tb;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, wdog, trip, dbg, erased;
    logic rst_hv, irq_hv, mon, brk, ill, stop, stop_en, fetch, unmap;
    logic wake, mask, trap_req, ack_o, pin_o, pin_oe, pin, wdis, internal_reset_line;
    logic bus_en, take, pcm1, xh, insn_done, trap_op, entry_done;
    logic [3:0] adr_i;
    logic [4:0] vec;
    logic [7:0] dly;
    logic [15:0] irq;
    logic [31:0] dat_i, dat_o, rd;
    int errors = 0;
    int checks = 0;
    int n, m;
    int cause_bit[6] = '{4, 4, 3, 5, 2, 1};
    // Open-drain reset pin with pull-up
    assign pin = pin_oe ? pin_o : 1'h1;
    reset_and_interrupt_arbiter u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .power_up_pulse_i(1'h0), .watchdog_ovf_i(wdog),
        .supply_trip_i(trip), .debug_entry_reset_i(dbg),
        .vectors_erased_i(erased), .rst_pin_i(pin), .rst_pin_o(pin_o),
        .rst_pin_oe_o(pin_oe), .rst_pin_hv_i(rst_hv),
        .irq_pin_hv_i(irq_hv), .monitor_mode_i(mon),
        .break_state_i(brk), .watchdog_disable_o(wdis),
        .illegal_op_i(ill), .stop_op_i(stop), .stop_enable_i(stop_en),
        .opcode_fetch_i(fetch), .unmapped_i(unmap),
        .short_wake_option_i(wake), .insn_done_i(insn_done),
        .mask_bit_i(mask), .trap_op_i(trap_op),
        .entry_done_i(entry_done), .irq_req_i(irq),
        .internal_reset_line_o(internal_reset_line), .bus_clk_en_o(bus_en),
        .int_take_o(take), .vector_o(vec), .pc_minus1_o(pcm1),
        .stack_index_high_o(xh)
    );
    cpu_model u_cpu (
        .clk_i(clk_i), .trap_req_i(trap_req), .entry_dly_i(dly),
        .int_take_i(take), .insn_done_o(insn_done),
        .trap_op_o(trap_op), .entry_done_o(entry_done)
    );
    ////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic test_done();
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Timeout counts as a mismatch
    task automatic bail();
        errors++;
        test_done();
    endtask
    // Compare one value
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Classic Wishbone single cycle, read data left in rd
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        int k;
        k = 0;
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'h1 && k < 50);
        if (ack_o !== 1'h1) bail();
        rd = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        we_i <= 1'h0;
        @(posedge clk_i);
    endtask
    // Wait for the interrupt take level
    task automatic wait_take(input logic v);
        int k;
        k = 0;
        while (take !== v && k < 300) begin
            @(posedge clk_i);
            k++;
        end
        if (take !== v) bail();
    endtask
    // Wait for run state, cycles spent left in n
    task automatic wait_run();
        n = 0;
        while (bus_en !== 1'h1 && n < 10000) begin
            @(posedge clk_i);
            n++;
        end
        if (bus_en !== 1'h1) bail();
    endtask
    // Time the pin-low phase and the internal reset tail
    task automatic measure(input int len);
        n = 0;
        while (pin_oe !== 1'h1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        chk("pin level", 0, pin);
        n = 0;
        while (pin_oe === 1'h1 && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        chk("pin low cycles", len, n);
        m = 0;
        while (internal_reset_line === 1'h1 && m < 100) begin
            @(posedge clk_i);
            m++;
        end
        chk("reset tail", 32, m);
    endtask
    // Pulse one internal reset source for a cycle
    task automatic fire(input int s);
        case (s)
            0: ill <= 1'h1;
            1: {stop, stop_en} <= 2'h2;
            2: {fetch, unmap} <= 2'h3;
            3: wdog <= 1'h1;
            4: {dbg, mon} <= 2'h3;
            default: trip <= 1'h1;
        endcase
        @(posedge clk_i);
        {ill, stop, fetch, unmap, wdog, dbg, trip} <= 7'h0;
        stop_en <= 1'h1;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end
    // Main sequence
    initial begin
        rst_i = 1'h1;
        {cyc_i, stb_i, we_i, wdog, trip, dbg, rst_hv, irq_hv} = 8'h0;
        {mon, brk, ill, stop, fetch, unmap, wake, trap_req} = 8'h0;
        {stop_en, erased, mask} = 3'h7;
        adr_i = 4'h0;
        dat_i = 32'h0;
        irq = 16'h0;
        dly = 8'h14;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        wait_run();
        wb(1'h0, 4'h0, 32'h0);
        chk("cause after power", 32'h80, rd);
        wb(1'h0, 4'h0, 32'h0);
        chk("cause cleared", 32'h0, rd);
        wb(1'h0, 4'h8, 32'h0);
        chk("enable reset", 32'h0, rd);
        wb(1'h0, 4'h2, 32'h0);
        chk("unmapped read", 32'h0, rd);
        for (int s = 0; s < 6; s++) begin
            fire(s);
            measure(s == 5 ? 4128 : 32);
            wait_run();
            wb(1'h0, 4'h0, 32'h0);
            chk("cause", 32'h1 << cause_bit[s], rd);
        end
        unmap <= 1'h1;
        @(posedge clk_i);
        unmap <= 1'h0;
        m = 0;
        repeat (10) begin
            @(posedge clk_i);
            if (pin_oe === 1'h1) m++;
        end
        chk("data fetch reset", 0, m);
        for (int i = 0; i < 16; i++) begin
            {mon, brk, rst_hv, irq_hv} <= i[3:0];
            repeat (2) @(posedge clk_i);
            chk("wdog off", (i[3] & (i[1] | i[0])) | (i[2] & i[1]), wdis);
        end
        {mon, brk, rst_hv, irq_hv} <= 4'h0;
        wb(1'h1, 4'h8, 32'h0000000a);
        irq <= 16'h000f;
        repeat (20) @(posedge clk_i);
        chk("masked take", 0, take);
        wb(1'h0, 4'h4, 32'h0);
        chk("raw requests", 32'h0000000f, rd);
        mask <= 1'h0;
        wait_take(1'h1);
        mask <= 1'h1;
        chk("vector", 2, vec);
        chk("pc minus one", 1, pcm1);
        chk("index high", 0, xh);
        wb(1'h1, 4'h8, 32'h0000000b);
        chk("held vector", 2, vec);
        wait_take(1'h0);
        irq <= 16'h000d;
        mask <= 1'h0;
        wait_take(1'h1);
        chk("pending at return", 1, vec);
        mask <= 1'h1;
        irq <= 16'h0;
        wait_take(1'h0);
        dly <= 8'h0;
        trap_req <= 1'h1;
        wait_take(1'h1);
        trap_req <= 1'h0;
        chk("trap vector", 32'h11, vec);
        chk("trap pc", 0, pcm1);
        wait_take(1'h0);
        mask <= 1'h0;
        for (int w = 1; w >= 0; w--) begin
            wake <= w[0];
            stop <= 1'h1;
            @(posedge clk_i);
            stop <= 1'h0;
            repeat (8) @(posedge clk_i);
            chk("stopped", 0, bus_en);
            irq <= 16'h0001;
            wait_run();
            chk("settle", 1, w ? (n >= 32 && n <= 40) : (n >= 4096 && n <= 4104));
            wait_take(1'h1);
            irq <= 16'h0;
            wait_take(1'h0);
        end
        test_done();
    end
endmodule // reset_and_interrupt_arbiter_tb
`default_nettype wire
